// file: core/dsl_regs.vh
// constants for the serial load and clear control block
`ifndef DSL_REGS_VH
`define DSL_REGS_VH
// ---------------------------------------------------------------
// frame layout (first bit shifted in is bit 23)
// ---------------------------------------------------------------
`define DSL_FRAME_BITS     24
`define DSL_CNT_W          5
`define DSL_ADDR_HI        23
`define DSL_ADDR_LO        22
`define DSL_CH_HI          21
`define DSL_CH_LO          20
`define DSL_CMD_HI         19
`define DSL_CMD_LO         18
`define DSL_DATA_HI        15
`define DSL_DATA_LO        0
// ---------------------------------------------------------------
// commands
// ---------------------------------------------------------------
`define DSL_CMD_WR_DATA    2'h0
`define DSL_CMD_WR_CLRCODE 2'h1
`define DSL_CMD_WR_CLREN   2'h2
`define DSL_CMD_READBACK   2'h3
// ---------------------------------------------------------------
// sizes and reset values
// ---------------------------------------------------------------
`define DSL_NUM_CH         4
`define DSL_DATA_W         16
`define DSL_FIFO_DEPTH     16
`define DSL_FIFO_AW        4
`define DSL_DATA_RST       16'h0000
`define DSL_CLRCODE_RST    16'h0000
`endif

// file: core/dsl_fifo.v
// synchronous fifo carrying received frames to the apply logic
`default_nettype none
module dsl_fifo #(
   parameter W  = 24,
   parameter D  = 16,
   parameter AW = 4
) (
   input  wire         core_clk_in,
   input  wire         rst_n_in,
   input  wire         wr_valid_in,
   output wire         wr_ready_out,
   input  wire [W-1:0] wr_data_in,
   output wire         rd_valid_out,
   input  wire         rd_ready_in,
   output wire [W-1:0] rd_data_out
);
   // ---------------------------------------------------------------
   // storage and pointers
   // ---------------------------------------------------------------
   reg [W-1:0] mem_q [0:D-1];   // word storage
   reg [AW-1:0] wp_q;           // write pointer
   reg [AW-1:0] rp_q;           // read pointer
   reg [AW:0]   cnt_q;          // fill level, one bit wider for full
   wire         push;
   wire         pop;

   assign wr_ready_out = (cnt_q != D[AW:0]);
   assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign rd_data_out  = mem_q[rp_q];
   assign push         = wr_valid_in & wr_ready_out;
   assign pop          = rd_valid_out & rd_ready_in;

   // memory write, no reset needed on data
   always @(posedge core_clk_in) begin
      if (push) begin
         mem_q[wp_q] <= wr_data_in;
      end
   end

   // pointers and level; simultaneous push and pop keep the level
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // dsl_fifo
`default_nettype wire

// file: core/dsl_ctrl.v
// serial load and clear control for a four channel output converter
//
// What this block does
// - frame select low gates input bits
// - data sampled on shift clock falling edge
// - readback shifts register out on serial output
// - board select pins decode device address
// - strobe low: output updates at frame end
// - strobe high: input only, output deferred
// - strobe falling edge updates all pending together
// - clear rising edge forces clear code
// - only clear enabled channels are cleared
// - clear high blocks all output writes
// - active low reset restores power-on state
`include "dsl_regs.vh"
`default_nettype none
module dsl_ctrl (
   input  wire          core_clk_in,
   input  wire          rst_n_in,
   input  wire          frame_sel_n_in,
   input  wire          shift_clk_in,
   input  wire          serial_in_line_in,
   output wire          serial_out_line_out,
   output reg           serial_out_oe_out,
   input  wire          output_load_strobe_n_in,
   input  wire          clear_in,
   input  wire          board_select_bit0_in,
   input  wire          board_select_bit1_in,
   output wire [63:0]   ch_out_out,
   output reg           frame_drop_out
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg [1:0] sync_a_q;          // frame select, two stages
   reg [1:0] sclk_a_q;          // shift clock, two stages
   reg [1:0] serial_in_line_a_q;          // serial data, two stages
   reg [1:0] output_load_strobe_n_a_q;          // load strobe, two stages
   reg [1:0] clr_a_q;           // clear, two stages
   reg [1:0] bs0_a_q;           // board select bit 0
   reg [1:0] bs1_a_q;           // board select bit 1
   reg       sync_p_q;          // previous synced frame select
   reg       sclk_p_q;          // previous synced shift clock
   reg       output_load_strobe_n_p_q;          // previous synced strobe
   reg       clr_p_q;           // previous synced clear

   // second stage of each chain is the only reader of the first
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sync_a_q <= 2'h3;
         sclk_a_q <= 2'h3;
         serial_in_line_a_q <= 2'h0;
         output_load_strobe_n_a_q <= 2'h3;
         clr_a_q  <= 2'h0;
         bs0_a_q  <= 2'h0;
         bs1_a_q  <= 2'h0;
         sync_p_q <= 1'b1;
         sclk_p_q <= 1'b1;
         output_load_strobe_n_p_q <= 1'b1;
         clr_p_q  <= 1'b0;
      end else begin
         sync_a_q <= {sync_a_q[0], frame_sel_n_in};
         sclk_a_q <= {sclk_a_q[0], shift_clk_in};
         serial_in_line_a_q <= {serial_in_line_a_q[0], serial_in_line_in};
         output_load_strobe_n_a_q <= {output_load_strobe_n_a_q[0], output_load_strobe_n_in};
         clr_a_q  <= {clr_a_q[0], clear_in};
         bs0_a_q  <= {bs0_a_q[0], board_select_bit0_in};
         bs1_a_q  <= {bs1_a_q[0], board_select_bit1_in};
         sync_p_q <= sync_a_q[1];
         sclk_p_q <= sclk_a_q[1];
         output_load_strobe_n_p_q <= output_load_strobe_n_a_q[1];
         clr_p_q  <= clr_a_q[1];
      end
   end

   wire sync_s    = sync_a_q[1];            // synced frame select
   wire frame_on  = ~sync_s;                // frame in progress
   wire sclk_fall = sclk_p_q & ~sclk_a_q[1];
   wire sclk_rise = ~sclk_p_q & sclk_a_q[1];
   wire frame_end = ~sync_p_q & sync_s;     // frame select rising
   wire output_load_strobe_n_s    = output_load_strobe_n_a_q[1];            // synced strobe level
   wire output_load_strobe_n_fall = output_load_strobe_n_p_q & ~output_load_strobe_n_s;
   wire clr_s     = clr_a_q[1];             // synced clear level
   wire clr_rise  = ~clr_p_q & clr_s;
   wire [1:0] my_addr = {bs1_a_q[1], bs0_a_q[1]};

   // ---------------------------------------------------------------
   // input shift register
   // ---------------------------------------------------------------
   reg [23:0]            shin_q;   // bits received this frame
   reg [`DSL_CNT_W-1:0]  bitc_q;   // bits counted, saturates
   wire                  fifo_rdy;
   // count widened on purpose to meet the 32 bit frame length constant
   wire                  push_ok = frame_end &&
                                   ({{(32-`DSL_CNT_W){1'b0}}, bitc_q} == `DSL_FRAME_BITS);

   // one bit per falling shift clock edge; counts are only
   // trustworthy while the shift clock is slower than half the core
   // clock, so faster hosts lose bits here
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         shin_q <= 24'h000000;
         bitc_q <= {`DSL_CNT_W{1'b0}};
      end else if (!frame_on) begin
         bitc_q <= {`DSL_CNT_W{1'b0}};
      end else if (sclk_fall) begin
         shin_q <= {shin_q[22:0], serial_in_line_a_q[1]};
         if (bitc_q != 5'h1f) begin
            bitc_q <= bitc_q + 1'b1;
         end
      end
   end

   // sticky flag when a complete frame meets a full fifo
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         frame_drop_out <= 1'b0;
      end else if (push_ok && !fifo_rdy) begin
         frame_drop_out <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // frame fifo
   // ---------------------------------------------------------------
   wire        pop_valid;
   wire [23:0] w;               // word at fifo head
   // apply only between frames so readback data is stable in a frame
   wire        pop_ready = sync_s;
   wire        pop       = pop_valid & pop_ready;

   dsl_fifo #(
      .W  (`DSL_FRAME_BITS),
      .D  (`DSL_FIFO_DEPTH),
      .AW (`DSL_FIFO_AW)
   ) u_fifo (
      .core_clk_in  (core_clk_in),
      .rst_n_in     (rst_n_in),
      .wr_valid_in  (push_ok),
      .wr_ready_out (fifo_rdy),
      .wr_data_in   (shin_q),
      .rd_valid_out (pop_valid),
      .rd_ready_in  (pop_ready),
      .rd_data_out  (w)
   );

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   wire [1:0]  w_cmd  = w[`DSL_CMD_HI:`DSL_CMD_LO];
   wire [1:0]  w_ch   = w[`DSL_CH_HI:`DSL_CH_LO];
   wire [15:0] w_data = w[`DSL_DATA_HI:`DSL_DATA_LO];
   wire        hit    = pop && (w[`DSL_ADDR_HI:`DSL_ADDR_LO] == my_addr);

   // ---------------------------------------------------------------
   // per channel registers
   // ---------------------------------------------------------------
   reg  [63:0] out_q;           // output registers, flat
   reg  [63:0] in_q;            // input registers, flat
   reg  [63:0] code_q;          // clear codes, flat
   reg  [3:0]  clren_q;         // clear enables
   reg  [3:0]  pend_q;          // input waits for strobe

   genvar gi;
   generate
      for (gi = 0; gi < `DSL_NUM_CH; gi = gi + 1) begin : g_ch
         wire sel   = hit && (w_ch == gi);
         wire wr_dt = sel && (w_cmd == `DSL_CMD_WR_DATA);

         // input register, clear code and enable settings
         always @(posedge core_clk_in) begin
            if (!rst_n_in) begin
               in_q[gi*16 +: 16]   <= `DSL_DATA_RST;
               code_q[gi*16 +: 16] <= `DSL_CLRCODE_RST;
               clren_q[gi]         <= 1'b0;
            end else begin
               if (wr_dt) begin
                  in_q[gi*16 +: 16] <= w_data;
               end
               if (sel && (w_cmd == `DSL_CMD_WR_CLRCODE)) begin
                  code_q[gi*16 +: 16] <= w_data;
               end
               if (sel && (w_cmd == `DSL_CMD_WR_CLREN)) begin
                  clren_q[gi] <= w_data[0];
               end
            end
         end

         // pending flag; a new deferred write wins over the transfer
         always @(posedge core_clk_in) begin
            if (!rst_n_in) begin
               pend_q[gi] <= 1'b0;
            end else if (wr_dt && output_load_strobe_n_s) begin
               pend_q[gi] <= 1'b1;
            end else if (output_load_strobe_n_fall && !clr_s) begin
               pend_q[gi] <= 1'b0;
            end
         end

         // output register; clear dominates every other update
         always @(posedge core_clk_in) begin
            if (!rst_n_in) begin
               out_q[gi*16 +: 16] <= `DSL_DATA_RST;
            end else if (clr_s) begin
               if (clr_rise && clren_q[gi]) begin
                  out_q[gi*16 +: 16] <= code_q[gi*16 +: 16];
               end
            // strobe low: frame-end update
            // a word landing with the strobe fall is newer than the
            // pending one, so it must not be lost to the transfer
            end else if (wr_dt && !output_load_strobe_n_s) begin
               out_q[gi*16 +: 16] <= w_data;
            end else if (output_load_strobe_n_fall && pend_q[gi]) begin
               out_q[gi*16 +: 16] <= in_q[gi*16 +: 16];
            end
         end
      end
   endgenerate

   assign ch_out_out = out_q;

   // ---------------------------------------------------------------
   // readback shifter
   // ---------------------------------------------------------------
   reg [15:0] sout_q;           // readback shift register

   // loaded between frames, shifted on rising shift clock so the
   // host sees a stable bit at its next falling edge
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sout_q            <= 16'h0000;
         serial_out_oe_out <= 1'b0;
      end else begin
         serial_out_oe_out <= frame_on;
         if (hit && (w_cmd == `DSL_CMD_READBACK)) begin
            sout_q <= out_q[{w_ch, 4'h0} +: 16];
         end else if (frame_on && sclk_rise) begin
            sout_q <= {sout_q[14:0], 1'b0};
         end
      end
   end

   assign serial_out_line_out = sout_q[15];
endmodule // dsl_ctrl
`default_nettype wire

// file: bench/dsl_host.sv
// host model driving the three wire serial port
`default_nettype none
module dsl_host (
   input  wire logic core_clk_in,
   input  wire logic sdo_in,
   output var  logic frame_sel_n_out,
   output var  logic shift_clk_out,
   output var  logic data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: frame high, clock parked high
   initial begin
      frame_sel_n_out = 1'b1;
      shift_clk_out = 1'b1;
      data_out = 1'b0;
   end
   // one frame, msb first; readback bits caught just before each rise
   task automatic send(input logic [23:0] w, output logic [23:0] rd);
      frame_sel_n_out <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      for (int i = 23; i >= 0; i--) begin
         data_out <= w[i];
         repeat (4) @(posedge core_clk_in);
         // 160 ns phases, far under limit
         shift_clk_out <= 1'b0;
         repeat (4) @(posedge core_clk_in);
         rd[i] = sdo_in;
         shift_clk_out <= 1'b1;
      end
      repeat (4) @(posedge core_clk_in);
      frame_sel_n_out <= 1'b1;
      // released data line shows the inverse, not a stale bit
      data_out <= ~data_out;
      repeat (4) @(posedge core_clk_in);
   endtask
endmodule // dsl_host
`default_nettype wire

// file: bench/dsl_ctrl_assertions.sv
// port level checks for the serial load and clear control
`default_nettype none
module dsl_ctrl_assertions (
   input wire logic        core_clk_in,
   input wire logic        rst_n_in,
   input wire logic        frame_sel_n_in,
   input wire logic        shift_clk_in,
   input wire logic        serial_out_line_out,
   input wire logic        serial_out_oe_out,
   input wire logic        output_load_strobe_n_in,
   input wire logic        clear_in,
   input wire logic [63:0] ch_out_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // ------------------------------------------------------------
   // checks; windows allow for the pin synchronisers
   // ------------------------------------------------------------
   a_reset_zeroes_all: assert property (disable iff (1'b0)
      !rst_n_in |=> ch_out_out == 64'h0 && !serial_out_oe_out) else $error("reset value");
   a_oe_idle_low: assert property (
      frame_sel_n_in [*5] |-> !serial_out_oe_out) else $error("oe outside frame");
   // enable follows the pin edge exactly three core cycles later
   a_oe_rise_frame: assert property (
      $rose(serial_out_oe_out) |-> !$past(frame_sel_n_in, 3) && $past(frame_sel_n_in, 4))
      else $error("oe rose off frame start");
   a_oe_fall_end: assert property (
      $fell(serial_out_oe_out) |-> $past(frame_sel_n_in, 3) && !$past(frame_sel_n_in, 4))
      else $error("oe fell off frame end");
   a_frame_holds_out: assert property (
      (!frame_sel_n_in && !clear_in && $stable(output_load_strobe_n_in)) [*8]
      |-> $stable(ch_out_out)) else $error("output moved in frame");
   a_strobe_defers: assert property (
      (output_load_strobe_n_in && !clear_in) [*8] |-> $stable(ch_out_out))
      else $error("output moved with strobe high");
   a_clear_blocks: assert property (
      clear_in [*8] |-> $stable(ch_out_out)) else $error("write during clear");
   a_sdo_holds: assert property (
      (!frame_sel_n_in && !shift_clk_in) [*3] |-> $stable(serial_out_line_out))
      else $error("readback moved off edge");
endmodule // dsl_ctrl_assertions
bind dsl_ctrl dsl_ctrl_assertions u_dsl_ctrl_assertions (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .frame_sel_n_in(frame_sel_n_in),
   .shift_clk_in(shift_clk_in), .serial_out_line_out(serial_out_line_out),
   .serial_out_oe_out(serial_out_oe_out), .output_load_strobe_n_in(output_load_strobe_n_in),
   .clear_in(clear_in), .ch_out_out(ch_out_out));
`default_nettype wire

// file: bench/dsl_ctrl_bench.sv
// self checking bench for the serial load and clear control
`default_nettype none
module dsl_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;     // 25 mhz core clock
   logic        rst_n = 1'b0;   // synchronous reset
   logic        strobe_n = 1'b1;
   logic        clr = 1'b0;
   logic [1:0]  bsel = 2'h2;    // board address of this device
   logic [23:0] rd;             // readback capture
   logic [63:0] exp_ch = 64'h0; // expected output registers
   wire         fsn, sck, sdi, serial_out_line, oe, drop;
   wire  [63:0] ch;
   int          n_mismatch = 0;
   int          n_checks = 0;
   initial forever #20 clk = ~clk;
   // an undriven readback line is shown inverted to the host
   dsl_host u_dsl_host (.core_clk_in(clk), .sdo_in(oe ? serial_out_line : ~serial_out_line), .frame_sel_n_out(fsn),
      .shift_clk_out(sck), .data_out(sdi));
   dsl_ctrl u_dsl_ctrl (.core_clk_in(clk), .rst_n_in(rst_n), .frame_sel_n_in(fsn),
      .shift_clk_in(sck), .serial_in_line_in(sdi), .serial_out_line_out(serial_out_line),
      .serial_out_oe_out(oe), .output_load_strobe_n_in(strobe_n), .clear_in(clr),
      .board_select_bit0_in(bsel[0]), .board_select_bit1_in(bsel[1]),
      .ch_out_out(ch), .frame_drop_out(drop));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] want);
      n_checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   // one frame to address a, then time for the word to land
   task automatic wr(input logic [1:0] a, c, m, input logic [15:0] d);
      u_dsl_host.send({a, c, m, 2'h0, d}, rd);
      repeat (8) @(posedge clk);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk(ch, 64'h0);
      chk({oe, drop, serial_out_line}, 64'h0);
      $display("reset done");
   endtask
   task automatic t_direct;
      strobe_n <= 1'b0;
      wr(2'h2, 2'h1, 2'h0, 16'h1234);
      exp_ch[31:16] = 16'h1234;
      chk(ch, exp_ch);
      // another board address must be ignored
      wr(2'h1, 2'h0, 2'h0, 16'hdead);
      chk(ch, exp_ch);
      $display("direct done");
   endtask
   task automatic t_defer;
      strobe_n <= 1'b1;
      wr(2'h2, 2'h0, 2'h0, 16'haaaa);
      wr(2'h2, 2'h2, 2'h0, 16'h5555);
      chk(ch, exp_ch);
      repeat (500) @(posedge clk);
      strobe_n <= 1'b0;
      repeat (8) @(posedge clk);
      exp_ch[15:0] = 16'haaaa;
      exp_ch[47:32] = 16'h5555;
      chk(ch, exp_ch);
      $display("defer done");
   endtask
   task automatic t_clear;
      wr(2'h2, 2'h3, 2'h1, 16'h5a5a);
      wr(2'h2, 2'h3, 2'h2, 16'h0001);
      wr(2'h2, 2'h1, 2'h1, 16'h0f0f);
      clr <= 1'b1;
      repeat (8) @(posedge clk);
      exp_ch[63:48] = 16'h5a5a;
      chk(ch, exp_ch);
      wr(2'h2, 2'h0, 2'h0, 16'hbeef);
      chk(ch, exp_ch);
      clr <= 1'b0;
      repeat (8) @(posedge clk);
      $display("clear done");
   endtask
   task automatic t_readback;
      wr(2'h2, 2'h3, 2'h3, 16'h0000);
      wr(2'h1, 2'h0, 2'h0, 16'h0000);
      chk(rd[23:8], 64'h5a5a);
      chk(ch, exp_ch);
      // between frames the readback driver is off, no frame lost
      chk({oe, drop}, 64'h0);
      $display("readback done");
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_direct();
      t_defer();
      t_clear();
      t_readback();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end
endmodule // dsl_ctrl_bench
`default_nettype wire
